// ### logic/cetl_bank.sv
/*
  One error-reporting bank: threshold control, error enable, status with
  code, model code, corrected count and valid flag.
  Assumes register writes come one cycle wide from the bus slave.
*/
module cetl_bank #(
  parameter int THR_BITS = 15
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        corrected_error_interrupt_cap,
  input  wire logic        wr_thr,
  input  wire logic        wr_en,
  input  wire logic        wr_stl,
  input  wire logic        wr_sth,
  input  wire logic [31:0] wdata,
  input  wire logic        err_evt,
  input  wire logic        err_corr,
  input  wire logic [15:0] err_code,
  input  wire logic [15:0] err_model,
  output logic      [31:0] thr_rd,
  output logic      [31:0] en_rd,
  output logic      [31:0] stl_rd,
  output logic      [31:0] sth_rd,
  output logic             corrected_error_interrupt_req
);

  logic [15:0] thresh_r;
  logic        sig_en_r;
  logic [31:0] enable_r;
  logic [15:0] code_r;
  logic [15:0] model_r;
  logic [cetl_pkg::CNT_W-1:0] count_r;
  logic        valid_r;
  logic        corrected_error_interrupt_req_r;

  // Compare only the implemented threshold bits
  localparam logic [15:0] THR_MASK = 16'((32'h1 << THR_BITS) - 32'h1);
  wire  [15:0] thr_eff   = thresh_r & THR_MASK;
  wire  [cetl_pkg::CNT_W-1:0] cnt_inc = count_r + 15'h0001;
  wire         log_ok    = err_evt & (err_corr | (|enable_r));
  wire         corr_hit  = log_ok & err_corr;
  wire         hit_thr   = corr_hit & sig_en_r & (thr_eff != 16'h0000)
                           & ({1'b0, cnt_inc} >= thr_eff);

  // Threshold control and error enable
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      thresh_r <= cetl_pkg::THRESH_RST;
      sig_en_r <= 1'b0;
      enable_r <= 32'h0000_0000;
    end
    else
    begin
      if (wr_thr)
      begin
        thresh_r <= wdata[15:0];
        sig_en_r <= wdata[cetl_pkg::THR_SIG_BIT] & corrected_error_interrupt_cap;
      end
      if (wr_en)
        enable_r <= wdata;
    end
  end

  // Status logging; hardware event wins over software write
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      code_r     <= cetl_pkg::CODE_NONE;
      model_r    <= 16'h0000;
      count_r    <= '0;
      valid_r    <= 1'b0;
      corrected_error_interrupt_req_r <= 1'b0;
    end
    else
    begin
      corrected_error_interrupt_req_r <= hit_thr;
      if (log_ok)
      begin
        code_r  <= err_code;
        model_r <= err_model;
        valid_r <= 1'b1;
        if (corr_hit)
          count_r <= hit_thr ? '0 : cnt_inc;
      end
      else
      begin
        if (wr_stl)
        begin
          code_r  <= wdata[15:0];
          model_r <= wdata[31:16];
        end
        if (wr_sth)
        begin
          count_r <= wdata[cetl_pkg::STAT_CNT_LO_HI +: cetl_pkg::CNT_W];
          valid_r <= wdata[cetl_pkg::STAT_VALID_HI];
        end
      end
    end
  end

  // Readback; max-value probe returns the implemented mask
  assign thr_rd   = {1'b0, sig_en_r, 14'h0000, thr_eff};
  assign en_rd    = enable_r;
  assign stl_rd   = {model_r, code_r};
  assign sth_rd   = {valid_r, 10'h000, count_r, 6'h00};
  assign corrected_error_interrupt_req = corrected_error_interrupt_req_r;

  chk_single_hit_pulse : assert property (@(posedge sys_clk) disable iff (!arst_n)
    hit_thr |=> corrected_error_interrupt_req && (count_r == '0)) else $error("threshold hit lost");
  chk_thr_one : assert property (@(posedge sys_clk) disable iff (!arst_n)
    (corr_hit && sig_en_r && thr_eff == 16'h0001) |=> corrected_error_interrupt_req) else $error("thr one missed");
  chk_valid_set : assert property (@(posedge sys_clk) disable iff (!arst_n)
    log_ok |=> valid_r && code_r == $past(err_code)) else $error("log not stored");
  chk_sig_cap : assert property (@(posedge sys_clk) disable iff (!arst_n)
    !corrected_error_interrupt_cap |-> !sig_en_r) else $error("signal bit without capability");

endmodule

// ### logic/cetl_logger.sv
/*
  Top of the corrected error threshold logger: AXI4-Lite register slave,
  a generated row of error banks, error code encoding, check exception
  gating and the masked corrected-error interrupt.
  Assumes error sources are one-cycle pulses on sys_clk; the bus init pin
  and strap pin are asynchronous and synchronised here.
*/
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
module cetl_logger #(
  parameter int          NUM_BANKS = 4,
  parameter int          THR_BITS  = 15,
  parameter logic [31:0] CORRECTED_ERROR_INTERRUPT_CAPS = 32'hffff_fffe
) (
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Error detection side
  input  wire logic                 err_valid,
  input  wire logic                 err_corrected,
  input  wire logic [2:0]           err_source,
  input  wire logic [9:0]           err_detail,
  input  wire logic [15:0]          err_model,
  input  wire logic [$clog2(NUM_BANKS)-1:0] err_bank,
  input  wire logic                 bus_init_input,
  input  wire logic                 bus_init_strap,
  // Results
  output logic                      check_exception,
  output logic [7:0]                check_vector,
  output logic                      corrected_error_interrupt
);

  localparam int BW = $clog2(NUM_BANKS);

  // Synchronisers for asynchronous pins
  logic [1:0] bus_init_input_sync_r;
  logic [1:0] strap_sync_r;
  logic       strap_seen_r;
  logic       bus_init_input_dly_r;
  logic       exc_r;
  logic [31:0] ctrl4_r;
  logic [31:0] lvt_r;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_init_input_sync_r <= 2'h0;
      strap_sync_r <= 2'h0;
    end
    else
    begin
      bus_init_input_sync_r <= {bus_init_input_sync_r[0], bus_init_input};
      strap_sync_r <= {strap_sync_r[0], bus_init_strap};
    end
  end

  // Strap caught once, after the synchroniser has refilled since reset
  logic [2:0] strap_fill_r;
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_fill_r <= 3'h0;
      strap_seen_r <= 1'b0;
    end
    else
    begin
      strap_fill_r <= {strap_fill_r[1:0], 1'b1};
      if (strap_fill_r == 3'h3)
        strap_seen_r <= strap_sync_r[1];
    end
  end

  // Error code encoding from source class
  cetl_pkg::cetl_src_t src;
  assign src = cetl_pkg::cetl_src_t'(err_source);
  logic [15:0] code_enc;
  always_comb
  begin
    case (src)
      cetl_pkg::CETL_SRC_UNCLASS:   code_enc = cetl_pkg::CODE_UNCLASS;
      cetl_pkg::CETL_SRC_UCODE_PAR: code_enc = cetl_pkg::CODE_UCODE_PAR;
      cetl_pkg::CETL_SRC_EXTERNAL:  code_enc = cetl_pkg::CODE_EXTERNAL;
      cetl_pkg::CETL_SRC_REDUND:    code_enc = cetl_pkg::CODE_REDUND;
      cetl_pkg::CETL_SRC_INT_PAR:   code_enc = cetl_pkg::CODE_INT_PAR;
      cetl_pkg::CETL_SRC_TIMER:     code_enc = cetl_pkg::CODE_TIMER;
      cetl_pkg::CETL_SRC_INTERNAL:  code_enc = {cetl_pkg::CODE_INT_PFX,
                                       (err_detail == 10'h000) ? 10'h001 : err_detail};
      default:                      code_enc = cetl_pkg::CODE_UNCLASS;
    endcase
  end

  // Bus init edge logs an external error into bank 0
  wire bus_init_input_rise = bus_init_input_sync_r[1] & ~bus_init_input_dly_r;
  wire exc_en     = ctrl4_r[cetl_pkg::CTRL4_EXC_BIT];

  // AXI4-Lite write path: address and data taken in either order
  logic        aw_have_r;
  logic        w_have_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        wr_hit;

  assign s_axi_awready = ~aw_have_r & ~bvalid_r;
  assign s_axi_wready  = ~w_have_r & ~bvalid_r;
  wire   wr_go         = aw_have_r & w_have_r & ~bvalid_r;
  wire   wr_full       = &s_axi_wstrb;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
      end
      if (wr_go)
      begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? 2'h0 : 2'h2;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // Write decode; partial strobes are ignored
  wire       wr_bank_area = (awaddr_r >= cetl_pkg::OFS_BANK_BASE);
  wire [7:0] wr_rel       = awaddr_r - cetl_pkg::OFS_BANK_BASE;
  wire [BW-1:0] wr_bidx   = wr_rel[4 +: BW];
  wire [1:0] wr_word      = wr_rel[3:2];
  wire       wr_bank_ok   = wr_bank_area && ({24'h0, wr_rel} < 32'(NUM_BANKS * 16));
  wire       wr_ctrl4     = wr_go & wr_full & (awaddr_r == cetl_pkg::OFS_CTRL4);
  wire       wr_lvt       = wr_go & wr_full & (awaddr_r == cetl_pkg::OFS_LVT);
  assign wr_hit           = (awaddr_r == cetl_pkg::OFS_CTRL4) | (awaddr_r == cetl_pkg::OFS_LVT) | wr_bank_ok;

  // Control register four and interrupt entry
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl4_r     <= cetl_pkg::CTRL4_RST;
      lvt_r       <= cetl_pkg::LVT_RST;
      bus_init_input_dly_r <= 1'b0;
      exc_r       <= 1'b0;
    end
    else
    begin
      if (wr_ctrl4)
        ctrl4_r <= wdata_r;
      if (wr_lvt)
        lvt_r <= wdata_r;
      bus_init_input_dly_r <= bus_init_input_sync_r[1];
      exc_r       <= bus_init_input_rise & strap_seen_r & exc_en;
    end
  end

  // Bank row
  logic [31:0] thr_rd [NUM_BANKS];
  logic [31:0] en_rd  [NUM_BANKS];
  logic [31:0] stl_rd [NUM_BANKS];
  logic [31:0] sth_rd [NUM_BANKS];
  logic [NUM_BANKS-1:0] corrected_error_interrupt_req;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi++)
    begin : g_bank
      wire sel   = wr_go & wr_full & wr_bank_ok & (wr_bidx == BW'(gi));
      wire hw    = (err_valid & (err_bank == BW'(gi))) | ((gi == 0) & bus_init_input_rise);
      wire [15:0] hw_code = (err_valid & (err_bank == BW'(gi))) ? code_enc : cetl_pkg::CODE_EXTERNAL;
      cetl_bank #(
        .THR_BITS (THR_BITS)
      ) u_bank (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .corrected_error_interrupt_cap  (CORRECTED_ERROR_INTERRUPT_CAPS[gi]),
        .wr_thr    (sel & (wr_word == cetl_pkg::BW_THRESH)),
        .wr_en     (sel & (wr_word == cetl_pkg::BW_ENABLE)),
        .wr_stl    (sel & (wr_word == cetl_pkg::BW_STAT_L)),
        .wr_sth    (sel & (wr_word == cetl_pkg::BW_STAT_H)),
        .wdata     (wdata_r),
        .err_evt   (hw),
        .err_corr  (err_valid & err_corrected & (err_bank == BW'(gi))),
        .err_code  (hw_code),
        .err_model (err_model),
        .thr_rd    (thr_rd[gi]),
        .en_rd     (en_rd[gi]),
        .stl_rd    (stl_rd[gi]),
        .sth_rd    (sth_rd[gi]),
        .corrected_error_interrupt_req  (corrected_error_interrupt_req[gi])
      );
    end
  endgenerate

  // Read decode
  wire       rd_bank_area = (s_axi_araddr >= cetl_pkg::OFS_BANK_BASE);
  wire [7:0] rd_rel       = s_axi_araddr - cetl_pkg::OFS_BANK_BASE;
  wire [BW-1:0] rd_bidx   = rd_rel[4 +: BW];
  wire       rd_bank_ok   = rd_bank_area && ({24'h0, rd_rel} < 32'(NUM_BANKS * 16));
  wire [31:0] cap_word    = {24'h0, 8'(NUM_BANKS)};
  wire [31:0] feat_word   = (32'h1 << cetl_pkg::FEAT_ARCH_BIT)
                          | (32'h1 << cetl_pkg::FEAT_EXC_BIT);
  wire [31:0] bank_word   = (rd_rel[3:2] == cetl_pkg::BW_THRESH) ? thr_rd[rd_bidx] :
                            (rd_rel[3:2] == cetl_pkg::BW_ENABLE) ? en_rd[rd_bidx]  :
                            (rd_rel[3:2] == cetl_pkg::BW_STAT_L) ? stl_rd[rd_bidx] : sth_rd[rd_bidx];
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb
  begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      cetl_pkg::OFS_CAP:     rd_mux = cap_word;
      cetl_pkg::OFS_FEATURE: rd_mux = feat_word;
      cetl_pkg::OFS_CTRL4:   rd_mux = ctrl4_r;
      cetl_pkg::OFS_LVT:     rd_mux = lvt_r;
      default:
      begin
        rd_mux = rd_bank_ok ? bank_word : 32'h0000_0000;
        rd_ok  = rd_bank_ok;
      end
    endcase
  end

  // AXI4-Lite read path
  assign s_axi_arready = ~rvalid_r;
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_ok ? 2'h0 : 2'h2;
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // Outputs
  assign s_axi_bvalid    = bvalid_r;
  assign s_axi_bresp     = bresp_r;
  assign s_axi_rvalid    = rvalid_r;
  assign s_axi_rdata     = rdata_r;
  assign s_axi_rresp     = rresp_r;
  assign check_exception = exc_r;
  assign check_vector    = 8'(cetl_pkg::EXC_VECTOR);
  assign corrected_error_interrupt = (|corrected_error_interrupt_req) & ~lvt_r[cetl_pkg::LVT_MASK_BIT];

  chk_exc_gate : assert property (@(posedge sys_clk) disable iff (!arst_n)
    check_exception |-> $past(strap_seen_r) && $past(exc_en)) else $error("exception not gated");
  chk_lvt_mask : assert property (@(posedge sys_clk) disable iff (!arst_n)
    lvt_r[cetl_pkg::LVT_MASK_BIT] |-> !corrected_error_interrupt) else $error("masked irq seen");
  chk_write_resp : assert property (@(posedge sys_clk) disable iff (!arst_n)
    wr_go |=> s_axi_bvalid) else $error("no write response");
  chk_feat_bits : assert property (@(posedge sys_clk) disable iff (!arst_n)
    feat_word[14] && feat_word[7]) else $error("feature flags wrong");

endmodule

// ### logic/cetl_pkg.sv
/*
  Package for the corrected error threshold logger: register offsets,
  field positions, reset values, error codes and field widths.
  Assumes an AXI4-Lite slave with 32-bit data and one word per register.
*/
package cetl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CAP       = 8'h00;
  localparam logic [7:0] OFS_FEATURE   = 8'h04;
  localparam logic [7:0] OFS_CTRL4     = 8'h08;
  localparam logic [7:0] OFS_LVT       = 8'h0c;
  localparam logic [7:0] OFS_BANK_BASE = 8'h40;
  localparam logic [7:0] OFS_BANK_STEP = 8'h10;
  // Word positions inside one bank window
  localparam logic [1:0] BW_THRESH = 2'h0;
  localparam logic [1:0] BW_ENABLE = 2'h1;
  localparam logic [1:0] BW_STAT_L = 2'h2;
  localparam logic [1:0] BW_STAT_H = 2'h3;

  // Field positions
  localparam int FEAT_ARCH_BIT   = 14;
  localparam int FEAT_EXC_BIT    = 7;
  localparam int CTRL4_EXC_BIT   = 6;
  localparam int THR_SIG_BIT     = 30;
  localparam int LVT_MASK_BIT    = 16;
  localparam int STAT_VALID_HI   = 31;  // Bit 63 of the 64-bit status
  localparam int STAT_CNT_LO_HI  = 6;   // Count bits 52:38 sit at 20:6 of high word
  localparam int CNT_W           = 15;
  localparam int CODE_W          = 16;
  localparam int EXC_VECTOR      = 18;

  // Reset values
  localparam logic [31:0] LVT_RST    = 32'h0001_0000;
  localparam logic [31:0] CTRL4_RST  = 32'h0000_0000;
  localparam logic [15:0] THRESH_RST = 16'h0000;

  // Simple error codes
  localparam logic [15:0] CODE_NONE      = 16'h0000;
  localparam logic [15:0] CODE_UNCLASS   = 16'h0001;
  localparam logic [15:0] CODE_UCODE_PAR = 16'h0002;
  localparam logic [15:0] CODE_EXTERNAL  = 16'h0003;
  localparam logic [15:0] CODE_REDUND    = 16'h0004;
  localparam logic [15:0] CODE_INT_PAR   = 16'h0005;
  localparam logic [15:0] CODE_TIMER     = 16'h0400;
  localparam logic [5:0]  CODE_INT_PFX   = 6'h01;

  typedef enum logic [2:0] {
    CETL_SRC_UNCLASS,
    CETL_SRC_UCODE_PAR,
    CETL_SRC_EXTERNAL,
    CETL_SRC_REDUND,
    CETL_SRC_INT_PAR,
    CETL_SRC_TIMER,
    CETL_SRC_INTERNAL
  } cetl_src_t;

endpackage

// ### verification/cetl_sw.sv
/*
  Software-side model of the logger: an AXI4-Lite master plus the
  firmware and handler routines that run over it.
  Assumes its tasks are entered just after a rising edge of sys_clk.
*/
module cetl_sw (
  input  wire logic        sys_clk,
  output logic      [7:0]  s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic      [7:0]  s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end

  // Byte address of one word in a bank window
  function automatic logic [7:0] ba(input int b, input logic [1:0] w);
    return cetl_pkg::OFS_BANK_BASE + 8'(b) * cetl_pkg::OFS_BANK_STEP + {4'h0, w, 2'b00};
  endfunction

  // One write: address and data offered together, response awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge sys_clk);
      if (!aw_ok && s_axi_awready === 1'b1)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do
      @(posedge sys_clk);
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // One read: address held until taken, data taken with rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
      @(posedge sys_clk);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do
      @(posedge sys_clk);
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Power-on clearing and logging enable of every bank
  task automatic init(input int nb);
    logic [1:0] r;
    for (int i = 0; i < nb; i++)
    begin
      wr(ba(i, cetl_pkg::BW_STAT_L), 32'h0, r);
      wr(ba(i, cetl_pkg::BW_STAT_H), 32'h0, r);
      wr(ba(i, cetl_pkg::BW_ENABLE), 32'hffff_ffff, r);
    end
  endtask

  // Handler visit of one owned bank: log a valid error, then clear
  task automatic svc(input int b, output logic [31:0] l, output logic [31:0] h);
    logic [1:0] r;
    l = 32'h0;
    rd(ba(b, cetl_pkg::BW_STAT_H), h, r);
    if (h[cetl_pkg::STAT_VALID_HI] === 1'b1)
    begin
      rd(ba(b, cetl_pkg::BW_STAT_L), l, r);
      wr(ba(b, cetl_pkg::BW_STAT_L), 32'h0, r);
      wr(ba(b, cetl_pkg::BW_STAT_H), 32'h0, r);
    end
  endtask
endmodule

// ### verification/tb_cetl_logger.sv
/*
  Self-checking bench for the corrected error threshold logger.
  Assumes the software model drives the register bus; error pins,
  clock and reset are driven here.
*/
module tb_cetl_logger;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NB = 4;
  localparam int TB = 12;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, check_vector;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, err_bank;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        err_valid, err_corrected, bus_init_input, bus_init_strap;
  logic [2:0]  err_source;
  logic [9:0]  err_detail;
  logic [15:0] err_model;
  logic        check_exception, corrected_error_interrupt;
  int          error_cnt = 0;
  int          checked = 0;
  int          seed = 32'h17194701;
  int          n_int = 0;
  int          n_exc = 0;

  cetl_logger #(.NUM_BANKS(NB), .THR_BITS(TB), .CORRECTED_ERROR_INTERRUPT_CAPS(32'hffff_fffe)) u_cetl_logger (
    .sys_clk(sys_clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .err_valid(err_valid), .err_corrected(err_corrected), .err_source(err_source),
    .err_detail(err_detail), .err_model(err_model), .err_bank(err_bank),
    .bus_init_input(bus_init_input), .bus_init_strap(bus_init_strap), .check_exception(check_exception),
    .check_vector(check_vector), .corrected_error_interrupt(corrected_error_interrupt));

  cetl_sw u_cetl_sw (
    .sys_clk(sys_clk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  always #5 sys_clk = ~sys_clk;

  // Pulse counters for the two event outputs
  always @(posedge sys_clk)
  begin
    if (corrected_error_interrupt === 1'b1)
      n_int <= n_int + 1;
    if (check_exception === 1'b1)
      n_exc <= n_exc + 1;
  end

  // Expected simple error code for a source and detail
  function automatic logic [15:0] code_of(input int s, input logic [9:0] dt);
    case (s)
      0: return 16'h0001;
      1: return 16'h0002;
      2: return 16'h0003;
      3: return 16'h0004;
      4: return 16'h0005;
      5: return 16'h0400;
      default: return {6'h01, (dt == 10'h0) ? 10'h001 : dt};
    endcase
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One error pulse from the detection side
  task automatic inject(input int s, input logic [9:0] dt, input logic [15:0] m, input int b, input logic c);
    err_source <= 3'(s);
    err_detail <= dt;
    err_model <= m;
    err_bank <= 2'(b);
    err_corrected <= c;
    err_valid <= 1'b1;
    @(posedge sys_clk);
    err_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    logic [31:0] d, sl, sh;
    logic [1:0]  r;
    logic [9:0]  dt;
    logic [15:0] m;
    int          k, b, s;
    {err_valid, err_corrected, err_source, err_detail, err_model, err_bank} = '0;
    bus_init_input = 1'b0;
    bus_init_strap = 1'b0;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    // Reset values, constants and unmapped places
    u_cetl_sw.rd(cetl_pkg::OFS_LVT, d, r);
    chk(d, 32'h0001_0000);
    u_cetl_sw.rd(cetl_pkg::OFS_CAP, d, r);
    chk(32'(d[7:0]), 32'(NB));
    u_cetl_sw.rd(cetl_pkg::OFS_FEATURE, d, r);
    chk(32'({d[14], d[7]}), 32'h3);
    chk(32'(check_vector), 32'h12);
    u_cetl_sw.rd(8'h20, d, r);
    chk({d[29:0], r}, 32'h2);
    u_cetl_sw.wr(8'h30, 32'h1, r);
    chk(32'(r), 32'h2);
    u_cetl_sw.init(NB);
    // Every source, random bank and model code, zero detail corner last
    for (int i = 0; i < 8; i++)
    begin
      s = (i < 7) ? i : 6;
      dt = (i < 7) ? 10'($random(seed)) : 10'h0;
      b = $unsigned($random(seed)) % NB;
      m = 16'($random(seed));
      inject(s, dt, m, b, 1'b0);
      u_cetl_sw.svc(b, sl, sh);
      chk(32'(sh[31]), 32'h1);
      chk(32'(sl[15:0]), 32'(code_of(s, dt)));
      chk(32'(sl[31:16]), 32'(m));
    end
    u_cetl_sw.rd(u_cetl_sw.ba(b, cetl_pkg::BW_STAT_L), d, r);
    chk(d, 32'h0);
    // Threshold probe, capability bit, programming below the maximum
    u_cetl_sw.wr(u_cetl_sw.ba(1, cetl_pkg::BW_THRESH), 32'h7fff, r);
    u_cetl_sw.rd(u_cetl_sw.ba(1, cetl_pkg::BW_THRESH), d, r);
    chk(32'(d[14:0]), (32'h1 << TB) - 32'h1);
    u_cetl_sw.wr(u_cetl_sw.ba(0, cetl_pkg::BW_THRESH), 32'h4000_0001, r);
    u_cetl_sw.rd(u_cetl_sw.ba(0, cetl_pkg::BW_THRESH), d, r);
    chk(32'(d[30]), 32'h0);
    k = 2 + $unsigned($random(seed)) % 4;
    u_cetl_sw.wr(u_cetl_sw.ba(1, cetl_pkg::BW_THRESH), 32'h4000_0000 | 32'(k), r);
    u_cetl_sw.rd(u_cetl_sw.ba(1, cetl_pkg::BW_THRESH), d, r);
    chk(32'(d[30]), 32'h1);
    u_cetl_sw.wr(cetl_pkg::OFS_LVT, 32'h0, r);
    repeat (k - 1) inject(0, 10'h0, 16'h0, 1, 1'b1);
    u_cetl_sw.rd(u_cetl_sw.ba(1, cetl_pkg::BW_STAT_H), d, r);
    chk(32'(d[20:6]), 32'(k - 1));
    chk(32'(n_int), 32'h0);
    inject(0, 10'h0, 16'h0, 1, 1'b1);
    chk(32'(n_int), 32'h1);
    // Threshold one interrupts every time; mask then holds it back
    u_cetl_sw.wr(u_cetl_sw.ba(1, cetl_pkg::BW_THRESH), 32'h4000_0001, r);
    repeat (3) inject(0, 10'h0, 16'h0, 1, 1'b1);
    chk(32'(n_int), 32'h4);
    u_cetl_sw.wr(cetl_pkg::OFS_LVT, 32'h0001_0000, r);
    inject(0, 10'h0, 16'h0, 1, 1'b1);
    chk(32'(n_int), 32'h4);
    // Bus init with observation strapped off: logged, no exception
    u_cetl_sw.wr(cetl_pkg::OFS_CTRL4, 32'h40, r);
    u_cetl_sw.rd(cetl_pkg::OFS_CTRL4, d, r);
    chk(d, 32'h40);
    bus_init_input <= 1'b1;
    repeat (6) @(posedge sys_clk);
    bus_init_input <= 1'b0;
    repeat (6) @(posedge sys_clk);
    u_cetl_sw.svc(0, sl, sh);
    chk(32'(sl[15:0]), 32'h3);
    chk(32'(n_exc), 32'h0);
    // Mid-run reset with observation strapped on: exception only when enabled
    bus_init_strap <= 1'b1;
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    u_cetl_sw.rd(cetl_pkg::OFS_LVT, d, r);
    chk(d, 32'h0001_0000);
    for (int e = 0; e < 2; e++)
    begin
      u_cetl_sw.wr(cetl_pkg::OFS_CTRL4, 32'(e) << 6, r);
      bus_init_input <= 1'b1;
      repeat (6) @(posedge sys_clk);
      bus_init_input <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk(32'(n_exc), 32'(e));
    end
    finish_test();
  end
endmodule
